// File: hdl/cpu_regs_consts.vh
// Constants for the memory-mapped CPU register file
`ifndef CPU_REGS_CONSTS_VH
`define CPU_REGS_CONSTS_VH

// ==========================================================
// Data page zero word addresses
`define ADDR_ACC_A_LOW       7'h08
`define ADDR_ACC_A_HIGH      7'h09
`define ADDR_ACC_A_GUARD     7'h0a
`define ADDR_ACC_B_LOW       7'h0b
`define ADDR_ACC_B_HIGH      7'h0c
`define ADDR_ACC_B_GUARD     7'h0d
`define ADDR_TEMP            7'h0e
`define ADDR_PATH_DECISIONS  7'h0f
`define ADDR_POINTER_BASE    7'h10
`define ADDR_STACK_TOP       7'h18
`define ADDR_CIRC_LENGTH     7'h19
`define ADDR_REPEAT_COUNT    7'h1a
`define ADDR_REPEAT_START    7'h1b
`define ADDR_REPEAT_END      7'h1c
`define ADDR_MEM_CONFIG      7'h1d
`define ADDR_PAGE_EXT        7'h1e

// ==========================================================
// Field layout
`define ACC_WIDTH            40
`define LOW_MSB              15
`define HIGH_LSB             16
`define HIGH_MSB             31
`define GUARD_LSB            32
`define GUARD_MSB            39
`define PAGE_EXT_WIDTH       7

// ==========================================================
// Reset values
`define RESET_WORD           16'h0000
`define RESET_ACC            40'h00_0000_0000
`define RESET_PAGE_EXT       7'h00

`endif

// File: hdl/cpu_register_file.v
// Memory-mapped CPU register set with operand and pointer side ports
// What this block does
// RULE1: Two independent 40-bit accumulators, A and B.
// RULE2: Each accumulator is mapped as low, high and guard slices.
// RULE3: Temporary register feeds one multiplier operand for multiply and MAC.
// RULE4: Temporary register supplies run-time shift count for shifted add/load/sub.
// RULE5: Dynamic bit test takes bit position from temporary register.
// RULE6: Dual add/sub metric operations read branch metric from temporary register.
// RULE7: Exponent detect writes temporary register; normalize uses it as shift.
// RULE8: Compare-select-store shifts a high-vs-low path decision into 16-bit register.
// RULE9: Eight 16-bit pointers, CPU read/write, modified by pointer update units.
// RULE10: Stack pointer always holds address of the last pushed element.
// RULE11: Push predecrements stack pointer, pop postincrements it.
// RULE12: Circular block length register feeds the pointer update units.
// RULE13: 16-bit block repeat count gives number of block repetitions.
// RULE14: Two 16-bit registers hold block repeat start and end addresses.
// RULE15: Memory configuration register drives on-chip memory configuration.
// RULE16: Program page extension holds upper 7 bits of program address.
// RULE17: Slices map to bits 15:0, 31:16 and 39:32.
// RULE18: Page zero CPU registers answer with no wait states.
// RULE19: A slice write changes only that slice.
`timescale 1ns/1ps
`include "cpu_regs_consts.vh"

module cpu_register_file (
   // Clock and reset
   input  wire        i_clk_sys,
   input  wire        i_reset_n,
   // Data page zero access
   input  wire [6:0]  i_mem_addr,
   input  wire        i_mem_wr,
   input  wire [15:0] i_mem_wdata,
   output wire [15:0] o_mem_rdata,
   output wire        o_mem_hit,
   output wire        o_mem_ready,
   // Accumulator writes from the arithmetic unit
   input  wire        i_acc_a_wr,
   input  wire        i_acc_b_wr,
   input  wire [39:0] i_acc_wdata,
   output wire [39:0] o_acc_a,
   output wire [39:0] o_acc_b,
   // Temporary register users
   input  wire        i_leading_bit_count_op,
   input  wire [15:0] i_exponent,
   output wire [15:0] o_mult_operand,
   output wire [5:0]  o_shift_count,
   output wire [3:0]  o_bit_position,
   output wire [15:0] o_branch_metric,
   output wire [5:0]  o_mantissa_shift_op_shift,
   // Compare-select-store
   input  wire        i_compare_select_store_op,
   input  wire        i_use_acc_b,
   output wire        o_path_decision,
   output wire [15:0] o_viterbi_path_decisions,
   // Pointer update units
   input  wire [7:0]  i_pointer_wr,
   input  wire [127:0] i_pointer_wdata,
   output wire [127:0] o_address_pointers,
   output wire [15:0] o_circular_block_length,
   // Stack
   input  wire        i_stack_push,
   input  wire        i_stack_pop,
   output wire [15:0] o_stack_top_pointer,
   output wire [15:0] o_push_address,
   // Block repeat
   input  wire        i_repeat_count_dec,
   output wire [15:0] o_block_repeat_count,
   output wire [15:0] o_block_repeat_start,
   output wire [15:0] o_block_repeat_end,
   // Memory configuration and program page
   input  wire        i_page_ext_wr,
   input  wire [6:0]  i_page_ext_wdata,
   output wire [15:0] o_memory_config_control,
   output wire [6:0]  o_program_page_extension
);

   // ==========================================================
   // Storage
   reg  [39:0] acc_a;
   reg  [39:0] acc_b;
   reg  [15:0] temp_value;
   reg  [15:0] viterbi_path_decisions;
   reg  [15:0] address_pointers [0:7];
   reg  [15:0] stack_top_pointer;
   reg  [15:0] circular_block_length;
   reg  [15:0] block_repeat_count;
   reg  [15:0] block_repeat_start;
   reg  [15:0] block_repeat_end;
   reg  [15:0] memory_config_control;
   reg  [6:0]  program_page_extension;
   reg  [15:0] next_rdata;
   reg         next_hit;

   wire [39:0] cmp_acc = i_use_acc_b ? acc_b : acc_a;
   wire        path_bit;

   // Decision: high word above low word, signed compare
   assign path_bit = ($signed(cmp_acc[`HIGH_MSB:`HIGH_LSB]) >
                      $signed(cmp_acc[`LOW_MSB:0]));                          // RULE8

   // ==========================================================
   // Accumulators
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_a <= `RESET_ACC;
         acc_b <= `RESET_ACC;
      end else begin
         // Arithmetic result wins over a mapped store in the same cycle
         if (i_acc_a_wr) begin
            acc_a <= i_acc_wdata;                                              // RULE1
         end else if (i_mem_wr) begin
            case (i_mem_addr)                                                  // RULE2
               `ADDR_ACC_A_LOW:   acc_a[`LOW_MSB:0] <= i_mem_wdata;            // RULE19
               `ADDR_ACC_A_HIGH:  acc_a[`HIGH_MSB:`HIGH_LSB] <= i_mem_wdata;   // RULE17
               `ADDR_ACC_A_GUARD: acc_a[`GUARD_MSB:`GUARD_LSB] <= i_mem_wdata[7:0];
               default: acc_a <= acc_a;
            endcase
         end
         if (i_acc_b_wr) begin
            acc_b <= i_acc_wdata;                                              // RULE1
         end else if (i_mem_wr) begin
            case (i_mem_addr)                                                  // RULE2
               `ADDR_ACC_B_LOW:   acc_b[`LOW_MSB:0] <= i_mem_wdata;            // RULE19
               `ADDR_ACC_B_HIGH:  acc_b[`HIGH_MSB:`HIGH_LSB] <= i_mem_wdata;   // RULE17
               `ADDR_ACC_B_GUARD: acc_b[`GUARD_MSB:`GUARD_LSB] <= i_mem_wdata[7:0];
               default: acc_b <= acc_b;
            endcase
         end
      end
   end

   // ==========================================================
   // Temporary and transition registers
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         temp_value             <= `RESET_WORD;
         viterbi_path_decisions <= `RESET_WORD;
      end else begin
         if (i_leading_bit_count_op) begin
            temp_value <= i_exponent;                                          // RULE7
         end else if (i_mem_wr && i_mem_addr == `ADDR_TEMP) begin
            temp_value <= i_mem_wdata;
         end
         // New decision enters at bit 0, older ones move up
         if (i_compare_select_store_op) begin
            viterbi_path_decisions <= {viterbi_path_decisions[14:0], path_bit}; // RULE8
         end else if (i_mem_wr && i_mem_addr == `ADDR_PATH_DECISIONS) begin
            viterbi_path_decisions <= i_mem_wdata;
         end
      end
   end

   // ==========================================================
   // Address pointers, one per entry
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pointer
         always @(posedge i_clk_sys or negedge i_reset_n) begin
            if (!i_reset_n) begin
               address_pointers[g] <= `RESET_WORD;
            end else if (i_pointer_wr[g]) begin
               address_pointers[g] <= i_pointer_wdata[16*g +: 16];             // RULE9
            end else if (i_mem_wr && i_mem_addr == (`ADDR_POINTER_BASE + g)) begin
               address_pointers[g] <= i_mem_wdata;                             // RULE9
            end
         end
         assign o_address_pointers[16*g +: 16] = address_pointers[g];
      end
   endgenerate

   // ==========================================================
   // Stack pointer and control registers
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stack_top_pointer      <= `RESET_WORD;
         circular_block_length  <= `RESET_WORD;
         block_repeat_count     <= `RESET_WORD;
         block_repeat_start     <= `RESET_WORD;
         block_repeat_end       <= `RESET_WORD;
         memory_config_control  <= `RESET_WORD;
         program_page_extension <= `RESET_PAGE_EXT;
      end else begin
         // Push and pop together cancel; a mapped write loses to stack motion
         if (i_stack_push && !i_stack_pop) begin
            stack_top_pointer <= stack_top_pointer - 16'h0001;                 // RULE11
         end else if (i_stack_pop && !i_stack_push) begin
            stack_top_pointer <= stack_top_pointer + 16'h0001;                 // RULE11
         end else if (i_mem_wr && i_mem_addr == `ADDR_STACK_TOP) begin
            stack_top_pointer <= i_mem_wdata;
         end
         if (i_mem_wr && i_mem_addr == `ADDR_CIRC_LENGTH) begin
            circular_block_length <= i_mem_wdata;                              // RULE12
         end
         if (i_repeat_count_dec) begin
            block_repeat_count <= block_repeat_count - 16'h0001;               // RULE13
         end else if (i_mem_wr && i_mem_addr == `ADDR_REPEAT_COUNT) begin
            block_repeat_count <= i_mem_wdata;                                 // RULE13
         end
         if (i_mem_wr && i_mem_addr == `ADDR_REPEAT_START) begin
            block_repeat_start <= i_mem_wdata;                                 // RULE14
         end
         if (i_mem_wr && i_mem_addr == `ADDR_REPEAT_END) begin
            block_repeat_end <= i_mem_wdata;                                   // RULE14
         end
         if (i_mem_wr && i_mem_addr == `ADDR_MEM_CONFIG) begin
            memory_config_control <= i_mem_wdata;                              // RULE15
         end
         if (i_page_ext_wr) begin
            program_page_extension <= i_page_ext_wdata;                        // RULE16
         end else if (i_mem_wr && i_mem_addr == `ADDR_PAGE_EXT) begin
            program_page_extension <= i_mem_wdata[6:0];                        // RULE16
         end
      end
   end

   // ==========================================================
   // Read mux, answered in the same cycle
   always @* begin
      next_rdata = `RESET_WORD;
      next_hit   = 1'b1;
      case (i_mem_addr)
         `ADDR_ACC_A_LOW:      next_rdata = acc_a[`LOW_MSB:0];                 // RULE17
         `ADDR_ACC_A_HIGH:     next_rdata = acc_a[`HIGH_MSB:`HIGH_LSB];
         `ADDR_ACC_A_GUARD:    next_rdata = {8'h00, acc_a[`GUARD_MSB:`GUARD_LSB]};
         `ADDR_ACC_B_LOW:      next_rdata = acc_b[`LOW_MSB:0];
         `ADDR_ACC_B_HIGH:     next_rdata = acc_b[`HIGH_MSB:`HIGH_LSB];
         `ADDR_ACC_B_GUARD:    next_rdata = {8'h00, acc_b[`GUARD_MSB:`GUARD_LSB]};
         `ADDR_TEMP:           next_rdata = temp_value;
         `ADDR_PATH_DECISIONS: next_rdata = viterbi_path_decisions;
         `ADDR_STACK_TOP:      next_rdata = stack_top_pointer;
         `ADDR_CIRC_LENGTH:    next_rdata = circular_block_length;
         `ADDR_REPEAT_COUNT:   next_rdata = block_repeat_count;
         `ADDR_REPEAT_START:   next_rdata = block_repeat_start;
         `ADDR_REPEAT_END:     next_rdata = block_repeat_end;
         `ADDR_MEM_CONFIG:     next_rdata = memory_config_control;
         `ADDR_PAGE_EXT:       next_rdata = {9'h000, program_page_extension};
         default: begin
            // Only 10h-17h fall through to the pointers; 1fh stays reserved
            if (i_mem_addr[6:3] == 4'h2) begin
               next_rdata = address_pointers[i_mem_addr[2:0]];
            end else begin
               next_hit = 1'b0;
            end
         end
      endcase
   end

   // Page zero CPU registers never stall the pipeline
   assign o_mem_ready = 1'b1;                                                  // RULE18
   assign o_mem_rdata = next_rdata;
   assign o_mem_hit   = next_hit;

   // ==========================================================
   // Operand taps of the temporary register
   assign o_mult_operand  = temp_value;                                        // RULE3
   assign o_shift_count   = temp_value[5:0];                                   // RULE4
   assign o_bit_position  = temp_value[3:0];                                   // RULE5
   assign o_branch_metric = temp_value;                                        // RULE6
   assign o_mantissa_shift_op_shift    = temp_value[5:0];                                   // RULE7

   assign o_acc_a                  = acc_a;
   assign o_acc_b                  = acc_b;
   assign o_path_decision          = path_bit;
   assign o_viterbi_path_decisions = viterbi_path_decisions;
   assign o_circular_block_length  = circular_block_length;                    // RULE12
   assign o_stack_top_pointer      = stack_top_pointer;                        // RULE10
   // Address a push will write to: already predecremented
   assign o_push_address           = stack_top_pointer - 16'h0001;             // RULE11
   assign o_block_repeat_count     = block_repeat_count;
   assign o_block_repeat_start     = block_repeat_start;
   assign o_block_repeat_end       = block_repeat_end;
   assign o_memory_config_control  = memory_config_control;
   assign o_program_page_extension = program_page_extension;

endmodule // cpu_register_file

// File: bench/cpu_register_file_properties.sv
// Concurrent checks on the register file ports
`timescale 1ns/1ps
module cpu_register_file_props (
   input wire        i_clk_sys,
   input wire        i_reset_n,
   input wire [6:0]  i_mem_addr,
   input wire        i_mem_wr,
   input wire [15:0] i_mem_wdata,
   input wire [15:0] o_mem_rdata,
   input wire        o_mem_hit,
   input wire        o_mem_ready,
   input wire        i_acc_a_wr,
   input wire [39:0] o_acc_a,
   input wire        i_leading_bit_count_op,
   input wire [15:0] i_exponent,
   input wire [5:0]  o_mantissa_shift_op_shift,
   input wire        i_compare_select_store_op,
   input wire        i_use_acc_b,
   input wire        o_path_decision,
   input wire [15:0] o_viterbi_path_decisions,
   input wire        i_stack_push,
   input wire        i_stack_pop,
   input wire [15:0] o_stack_top_pointer,
   input wire [15:0] o_push_address
);
   // ==========================================================
   // Steps
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   sequence s_push; i_stack_push && !i_stack_pop; endsequence
   sequence s_pop; i_stack_pop && !i_stack_push; endsequence
   sequence s_low_wr; i_mem_wr && i_mem_addr == 7'h08 && !i_acc_a_wr; endsequence
   sequence s_high_wr; i_mem_wr && i_mem_addr == 7'h09 && !i_acc_a_wr; endsequence
   // ==========================================================
   // Properties
   AST_NO_WAIT: assert property (o_mem_ready)
      else $error("register access stalled");
   AST_MAP: assert property (o_mem_hit == (i_mem_addr inside {[7'h08:7'h1e]}))
      else $error("mapped range decode wrong");
   AST_GUARD_RD: assert property (i_mem_addr == 7'h0a |-> o_mem_rdata == {8'h00, o_acc_a[39:32]})
      else $error("guard slice read wrong");
   AST_HIGH_WR: assert property (s_high_wr |=> o_acc_a[31:16] == $past(i_mem_wdata))
      else $error("high word write lost");
   AST_SLICE_KEEP: assert property (s_low_wr |=> (o_acc_a >> 16) == ($past(o_acc_a) >> 16))
      else $error("low word write disturbed other bits");
   AST_MANTISSA_SHIFT_OP: assert property (i_leading_bit_count_op |=> o_mantissa_shift_op_shift == 6'($past(i_exponent)))
      else $error("exponent not used as shift");
   AST_DECIDE: assert property (!i_use_acc_b |-> o_path_decision == ($signed(o_acc_a[31:16]) > $signed(o_acc_a[15:0])))
      else $error("path decision wrong");
   AST_CSS: assert property (i_compare_select_store_op |=> o_viterbi_path_decisions == (($past(o_viterbi_path_decisions) << 1) | $past(o_path_decision)))
      else $error("decision not shifted in");
   AST_PUSH: assert property (s_push |=> o_stack_top_pointer == $past(o_stack_top_pointer) - 16'h0001)
      else $error("push did not predecrement");
   AST_POP: assert property (s_pop |=> o_stack_top_pointer == $past(o_stack_top_pointer) + 16'h0001)
      else $error("pop did not postincrement");
   AST_PUSH_ADDR: assert property (o_push_address == o_stack_top_pointer - 16'h0001)
      else $error("push address wrong");
endmodule // cpu_register_file_props
bind cpu_register_file cpu_register_file_props u_props (.*);

// File: bench/pipeline_model.sv
// Pipeline and pointer unit stand-in that drives the side strobes
`timescale 1ns/1ps
module pipeline_model (
   // Clock
   input  wire         i_clk_sys,
   // Side strobes
   output reg  [1:0]   o_push_pop,
   output reg          o_dec,
   output reg  [7:0]   o_ptr_wr,
   output reg  [127:0] o_ptr_wdata,
   output reg          o_page_wr,
   output reg  [6:0]   o_page_wdata
);
   initial begin
      {o_push_pop, o_dec, o_ptr_wr, o_ptr_wdata, o_page_wr, o_page_wdata} = 0;
   end
   // Released data shows the inverse so a stale value never looks right
   task strobe(input [1:0] pp, input dc, input [7:0] pw, input [127:0] d, input gw,
               input [6:0] gd);
      @(posedge i_clk_sys) #1;
      {o_push_pop, o_dec, o_ptr_wr, o_ptr_wdata, o_page_wr, o_page_wdata} = {pp, dc, pw, d, gw, gd};
      @(posedge i_clk_sys) #1;
      {o_push_pop, o_dec, o_ptr_wr, o_page_wr} = 12'h000;
      {o_ptr_wdata, o_page_wdata} = ~{d, gd};
   endtask
endmodule // pipeline_model

// File: bench/tb_cpu_register_file.sv
// Self-checking bench for the CPU register file
`timescale 1ns/1ps
module tb_cpu_register_file;
   reg          i_clk_sys, i_reset_n, i_mem_wr, i_acc_a_wr, i_acc_b_wr, i_use_acc_b;
   reg          i_leading_bit_count_op, i_compare_select_store_op;
   reg  [6:0]   i_mem_addr;
   reg  [15:0]  i_mem_wdata, i_exponent;
   reg  [39:0]  i_acc_wdata;
   wire         i_stack_push, i_stack_pop, i_repeat_count_dec, i_page_ext_wr;
   wire         o_mem_hit, o_mem_ready, o_path_decision;
   wire [6:0]   i_page_ext_wdata, o_program_page_extension;
   wire [7:0]   i_pointer_wr;
   wire [127:0] i_pointer_wdata, o_address_pointers;
   wire [15:0]  o_mem_rdata, o_mult_operand, o_branch_metric, o_viterbi_path_decisions;
   wire [15:0]  o_circular_block_length, o_stack_top_pointer, o_push_address;
   wire [15:0]  o_block_repeat_count, o_block_repeat_start, o_block_repeat_end;
   wire [15:0]  o_memory_config_control;
   wire [39:0]  o_acc_a, o_acc_b;
   wire [5:0]   o_shift_count, o_mantissa_shift_op_shift;
   wire [3:0]   o_bit_position;
   integer      failures, n_tests, k;
   cpu_register_file u_dut (.*);
   pipeline_model u_pipe (.i_clk_sys(i_clk_sys), .o_push_pop({i_stack_push, i_stack_pop}),
      .o_dec(i_repeat_count_dec), .o_ptr_wr(i_pointer_wr), .o_ptr_wdata(i_pointer_wdata),
      .o_page_wr(i_page_ext_wr), .o_page_wdata(i_page_ext_wdata));
   // ==========================================================
   // Shared tasks
   task chk(input string name, input [39:0] seen, input [39:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input [6:0] a, input [15:0] d);
      @(posedge i_clk_sys) #1;
      {i_mem_addr, i_mem_wdata, i_mem_wr} = {a, d, 1'b1};
      @(posedge i_clk_sys) #1;
      {i_mem_wdata, i_mem_wr} = {~d, 1'b0};
   endtask
   task rdc(input [6:0] a, input [15:0] exp);
      i_mem_addr = a;
      #1 chk("read data", o_mem_rdata, exp);
      chk("hit", o_mem_hit, a >= 7'h08 && a <= 7'h1e);
   endtask
   // Sides: acc A load, acc B load, exponent, compare-select-store
   task hw(input [3:0] s, input [39:0] d);
      @(posedge i_clk_sys) #1;
      {i_acc_a_wr, i_acc_b_wr, i_leading_bit_count_op, i_compare_select_store_op} = s;
      {i_acc_wdata, i_exponent} = {d, d[15:0]};
      @(posedge i_clk_sys) #1;
      {i_acc_a_wr, i_acc_b_wr, i_leading_bit_count_op, i_compare_select_store_op} = 4'h0;
      {i_acc_wdata, i_exponent} = ~{d, d[15:0]};
   endtask
   // ==========================================================
   // Scenarios
   task t_reset_map;
      for (k = 0; k < 32; k = k + 1) rdc(k, 16'h0000);
      wr(7'h1f, 16'hffff);
      wr(7'h05, 16'hffff);
      rdc(7'h1f, 16'h0000);
      rdc(7'h05, 16'h0000);
      chk("ready", o_mem_ready, 1'b1);
   endtask
   task t_regs;
      for (k = 14; k < 31; k = k + 1) wr(k, 16'h5a00 | k);
      for (k = 14; k < 30; k = k + 1) rdc(k, 16'h5a00 | k);
      rdc(7'h1e, 16'h001e);
      chk("pointer 3", o_address_pointers[63:48], 16'h5a13);
      chk("block length", o_circular_block_length, 16'h5a19);
      chk("repeat count", o_block_repeat_count, 16'h5a1a);
      chk("repeat start", o_block_repeat_start, 16'h5a1b);
      chk("repeat end", o_block_repeat_end, 16'h5a1c);
      chk("mem config", o_memory_config_control, 16'h5a1d);
   endtask
   task t_acc;
      wr(7'h08, 16'h5678);
      wr(7'h09, 16'h1234);
      wr(7'h0a, 16'habcd);
      chk("acc a", o_acc_a, 40'hcd_1234_5678);
      rdc(7'h0a, 16'h00cd);
      hw(4'h4, 40'hff_ffff_ffff);
      wr(7'h0c, 16'h0000);
      chk("acc b", o_acc_b, 40'hff_0000_ffff);
      chk("acc a kept", o_acc_a, 40'hcd_1234_5678);
   endtask
   task t_temp;
      hw(4'h2, 40'h2b);
      chk("mult operand", o_mult_operand, 16'h002b);
      chk("shift count", o_shift_count, 6'h2b);
      chk("bit position", o_bit_position, 4'hb);
      chk("branch metric", o_branch_metric, 16'h002b);
      chk("mantissa_shift_op shift", o_mantissa_shift_op_shift, 6'h2b);
      rdc(7'h0e, 16'h002b);
   endtask
   task t_css;
      wr(7'h0f, 16'h0000);
      hw(4'h8, 40'h00_0005_0003);
      hw(4'h1, 40'h0);
      hw(4'h4, 40'h00_8000_0001);
      i_use_acc_b = 1'b1;
      hw(4'h1, 40'h0);
      chk("path decisions", o_viterbi_path_decisions, 16'h0002);
   endtask
   task t_stack;
      wr(7'h18, 16'h0100);
      u_pipe.strobe(2'b10, 1'b0, 8'h00, 128'h0, 1'b0, 7'h00);
      u_pipe.strobe(2'b10, 1'b0, 8'h00, 128'h0, 1'b0, 7'h00);
      chk("push address", o_push_address, 16'h00fd);
      u_pipe.strobe(2'b01, 1'b0, 8'h00, 128'h0, 1'b0, 7'h00);
      u_pipe.strobe(2'b11, 1'b0, 8'h00, 128'h0, 1'b0, 7'h00);
      rdc(7'h18, 16'h00ff);
      u_pipe.strobe(2'b00, 1'b1, 8'h20, 128'hbeef << 80, 1'b1, 7'h55);
      rdc(7'h15, 16'hbeef);
      rdc(7'h13, 16'h5a13);
      chk("repeat count", o_block_repeat_count, 16'h5a19);
      chk("page ext", o_program_page_extension, 7'h55);
   endtask
   // ==========================================================
   // Run control
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #40000;
      failures = failures + 1;
      tally_and_finish;
   end
   initial begin
      {i_reset_n, i_mem_wr, i_acc_a_wr, i_acc_b_wr, i_use_acc_b} = 5'h00;
      {i_leading_bit_count_op, i_compare_select_store_op} = 2'h0;
      {i_mem_addr, i_mem_wdata, i_exponent, i_acc_wdata} = 0;
      {failures, n_tests} = 0;
      repeat (5) @(posedge i_clk_sys);
      #1 i_reset_n = 1'b1;
      t_reset_map;
      t_regs;
      t_acc;
      t_temp;
      t_css;
      t_stack;
      tally_and_finish;
   end
endmodule // tb_cpu_register_file
